// ===== see_slave.v
// serial-bus slave of a 4096-byte nonvolatile byte memory with its array
// assumes: pins are asynchronous to mclk; sck is far slower than mclk
`timescale 1ns/1ps
`default_nettype none
`include "see_defines.vh"

// Behaviour
// - chip select high: deselect, output high impedance
// - started programming cycle finishes regardless of select
// - select rise after valid write starts cycle
// - sample input on clock rise, shift out on fall
// - pin low and gate bit set refuse status writes
// - pin falling during cycle leaves it unharmed
// - gate bit low makes protect pin ignored
// - pause starts only while clock is low
// - paused: clock and data ignored, sequence state kept until deselect
// - resume only while clock low, continue exactly
// - hold low always puts output in high impedance
// - eight-bit instructions, all fields msb first
// - read: opcode, 16-bit address, top four ignored
// - read pointer increments, wraps 0FFFh to 0000h
// - latch set only by select rise after opcode
// - write: opcode, address, up to 32 bytes
// - write counter wraps within its 32-byte page
// - write committed only after whole data byte
// - during busy status reads served, array reads not
// - opcode values decoded as listed
// - latch cleared at power-up and after writes
// - busy flag bit zero reads one while writing
module see_slave #(
	parameter WRITE_CYCLES = `SEE_TWC_CYCLES
) (
	// clock, reset, enable
	input wire mclk,
	input wire rst,
	input wire clk_en,
	// serial link pins
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire hold_n,
	input wire wp_n,
	output reg so_out,
	output reg so_oe,
	// status bits
	output reg busy_flag,
	output reg write_latch_flag,
	output reg protect_pin_gate_bit,
	output reg block_guard_bit0,
	output reg block_guard_bit1
);

	// one-hot sequence states
	localparam [6:0] S_CMD = 7'h01; // waiting for instruction byte
	localparam [6:0] S_ADDR = 7'h02; // two address bytes
	localparam [6:0] S_RDAT = 7'h04; // array data shifting out
	localparam [6:0] S_WDAT = 7'h08; // page data shifting in
	localparam [6:0] S_SRD = 7'h10; // status shifting out
	localparam [6:0] S_SWR = 7'h20; // status byte shifting in
	localparam [6:0] S_IGN = 7'h40; // idle until select rises

	// synchroniser stages: first flops feed only the second
	reg [4:0] sync_a;
	reg [4:0] sync_b;
	reg sck_d; // previous synced clock, for edge detection
	reg cs_d; // previous synced select
	wire cs_s = sync_b[0];
	wire sck_s = sync_b[1];
	wire si_s = sync_b[2];
	wire hold_s = sync_b[3];
	wire wp_s = sync_b[4];

	// array and page buffer
	reg [7:0] mem [0:`SEE_DEPTH-1];
	reg [7:0] page_buf [0:`SEE_PAGE_BYTES-1];
	reg [`SEE_PAGE_BYTES-1:0] page_mask; // bytes loaded this sequence

	// sequence state
	reg [6:0] state;
	reg [2:0] bit_cnt; // bits of current byte taken
	reg [7:0] in_sr; // input shift register
	reg [7:0] out_sr; // output shift register
	reg [7:0] opcode; // instruction register
	reg addr_hi_done; // first address byte taken
	reg [`SEE_ADDR_W-1:0] addr; // address pointer
	reg is_read; // address phase belongs to a read
	reg byte_done; // last rise closed a whole data byte
	reg [7:0] stat_new; // status byte awaiting commit
	reg armed; // select seen low since power-up
	reg paused; // hold in effect

	// internal write cycle
	reg [31:0] busy_cnt;
	reg [5:0] copy_idx;
	reg stat_pend; // cycle is a status write
	reg [`SEE_ADDR_W-`SEE_PAGE_W-1:0] page_no; // page under programming

	// qualified edges
	wire active = armed & ~cs_s & ~paused;
	wire sck_rise = active & sck_s & ~sck_d;
	wire sck_fall = active & ~sck_s & sck_d;
	wire cs_rise = cs_s & ~cs_d;
	wire [7:0] byte_in = {in_sr[6:0], si_s};
	wire byte_end = (bit_cnt == `SEE_LAST_BIT);

	// status byte assembly, used for loading and readback
	function [7:0] stat_byte;
		input gate;
		input g1;
		input g0;
		input latch;
		input busy;
		begin
			stat_byte = 8'h00;
			stat_byte[`SEE_ST_GATE] = gate;
			stat_byte[`SEE_ST_GUARD1] = g1;
			stat_byte[`SEE_ST_GUARD0] = g0;
			stat_byte[`SEE_ST_LATCH] = latch;
			stat_byte[`SEE_ST_BUSY] = busy;
		end
	endfunction

	wire [7:0] stat_now = stat_byte(protect_pin_gate_bit,
		block_guard_bit1, block_guard_bit0, write_latch_flag, busy_flag);

	// pin synchronisers; select idles high, hold idles high
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync_a <= 5'h19;
			sync_b <= 5'h19;
			sck_d <= 1'b0;
			cs_d <= 1'b1;
		end else if (clk_en) begin
			sync_a <= {wp_n, hold_n, si, sck, cs_n};
			sync_b <= sync_a;
			sck_d <= sck_s;
			cs_d <= cs_s;
		end
	end

	// pause control: enter and resume only while clock is low; deselect ends it at once
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			paused <= 1'b0;
		end else if (clk_en) begin
			if (cs_s) begin
				paused <= 1'b0;
			end else if (!paused && !hold_s && !sck_s) begin
				paused <= 1'b1;
			end else if (paused && hold_s && !sck_s) begin
				paused <= 1'b0;
			end
		end
	end

	// serial output: changes after the clock falls, tri-stated on
	// deselect, pause or any hold low; the synced hold costs a few
	// mclk cycles of latency, well inside one link clock period
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			so_out <= 1'b0;
			so_oe <= 1'b0;
		end else if (clk_en) begin
			so_oe <= armed & ~cs_s & hold_s & ~paused &
				((state == S_RDAT) | (state == S_SRD));
			if (cs_s) begin
				so_out <= 1'b0;
			end else if (sck_fall) begin
				so_out <= out_sr[7];
			end
		end
	end

	// sequence engine; paused edges are masked so nothing moves
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= S_CMD;
			bit_cnt <= 3'h0;
			in_sr <= 8'h00;
			out_sr <= 8'h00;
			opcode <= 8'h00;
			addr_hi_done <= 1'b0;
			addr <= {`SEE_ADDR_W{1'b0}};
			is_read <= 1'b0;
			byte_done <= 1'b0;
			stat_new <= 8'h00;
			armed <= 1'b0;
			page_mask <= {`SEE_PAGE_BYTES{1'b0}};
			write_latch_flag <= 1'b0;
			busy_flag <= 1'b0;
			busy_cnt <= 32'h0000_0000;
			copy_idx <= 6'h00;
			stat_pend <= 1'b0;
			page_no <= {(`SEE_ADDR_W-`SEE_PAGE_W){1'b0}};
			protect_pin_gate_bit <= 1'b0;
			block_guard_bit0 <= 1'b0;
			block_guard_bit1 <= 1'b0;
		end else if (clk_en) begin
			// power-up needs one low on select first
			if (!cs_s) begin
				armed <= 1'b1;
			end

			// internal write cycle runs whatever select does
			if (busy_flag) begin
				if (!stat_pend && !copy_idx[5]) begin
					if (page_mask[copy_idx[4:0]]) begin
						mem[{page_no, copy_idx[4:0]}] <=
							page_buf[copy_idx[4:0]];
					end
					copy_idx <= copy_idx + 6'h01;
				end
				if (busy_cnt >= WRITE_CYCLES - 1) begin
					busy_flag <= 1'b0;
					write_latch_flag <= 1'b0;
					if (stat_pend) begin
						protect_pin_gate_bit <= stat_new[`SEE_ST_GATE];
						block_guard_bit1 <= stat_new[`SEE_ST_GUARD1];
						block_guard_bit0 <= stat_new[`SEE_ST_GUARD0];
					end
				end else begin
					busy_cnt <= busy_cnt + 32'h0000_0001;
				end
			end

			if (cs_rise) begin
				// close the sequence; only whole bytes commit
				state <= S_CMD;
				bit_cnt <= 3'h0;
				addr_hi_done <= 1'b0;
				byte_done <= 1'b0;
				// a bare opcode frame: exactly eight bits, nothing more
				if (state == S_IGN && bit_cnt == 3'h0 &&
					!byte_done) begin
					if (opcode == `SEE_OP_LATCH_SET) begin
						write_latch_flag <= 1'b1;
					end else if (opcode == `SEE_OP_LATCH_CLR &&
						!busy_flag) begin
						write_latch_flag <= 1'b0;
					end
				end else if (state == S_WDAT && byte_done &&
					!busy_flag) begin
					busy_flag <= 1'b1;
					busy_cnt <= 32'h0000_0000;
					copy_idx <= 6'h00;
					stat_pend <= 1'b0;
					page_no <= addr[`SEE_ADDR_W-1:`SEE_PAGE_W];
				end else if (state == S_IGN && byte_done &&
					opcode == `SEE_OP_STAT_WR &&
					!busy_flag &&
					!(!wp_s && protect_pin_gate_bit)) begin
					// pin is judged here only; later changes cannot
					// touch a cycle that has started
					busy_flag <= 1'b1;
					busy_cnt <= 32'h0000_0000;
					stat_pend <= 1'b1;
				end
			end else if (cs_s) begin
				state <= S_CMD;
				bit_cnt <= 3'h0;
			end else if (sck_rise) begin
				// one bit in on every rise, msb first
				in_sr <= byte_in;
				bit_cnt <= bit_cnt + 3'h1;
				byte_done <= 1'b0;
				out_sr <= {out_sr[6:0], 1'b0};
				// any bit past a finished frame spoils a pending latch
				// or status commit, so a later select rise does nothing
				if (state == S_IGN) begin
					opcode <= `SEE_OP_NONE;
				end
				if (byte_end) begin
					case (state)
					S_CMD: begin
						opcode <= byte_in;
						page_mask <= {`SEE_PAGE_BYTES{1'b0}};
						case (byte_in)
						`SEE_OP_READ: begin
							is_read <= 1'b1;
							state <= busy_flag ? S_IGN : S_ADDR;
						end
						`SEE_OP_WRITE: begin
							is_read <= 1'b0;
							state <= (write_latch_flag && !busy_flag) ?
								S_ADDR : S_IGN;
						end
						`SEE_OP_STAT_RD: begin
							out_sr <= stat_now;
							state <= S_SRD;
						end
						`SEE_OP_STAT_WR: begin
							state <= write_latch_flag ? S_SWR : S_IGN;
						end
						`SEE_OP_LATCH_SET: state <= S_IGN;
						`SEE_OP_LATCH_CLR: state <= S_IGN;
						default: state <= S_IGN;
						endcase
					end
					S_ADDR: begin
						if (!addr_hi_done) begin
							// top four address bits are dropped
							addr_hi_done <= 1'b1;
							addr[`SEE_ADDR_W-1:8] <= byte_in[3:0];
						end else begin
							addr[7:0] <= byte_in;
							if (is_read) begin
								out_sr <= mem[{addr[`SEE_ADDR_W-1:8],
									byte_in}];
								state <= S_RDAT;
							end else begin
								state <= S_WDAT;
							end
						end
					end
					S_RDAT: begin
						// next byte queued; pointer wraps at top
						addr <= addr + 12'h001;
						out_sr <= mem[addr + 12'h001];
					end
					S_WDAT: begin
						page_buf[addr[`SEE_PAGE_W-1:0]] <= byte_in;
						page_mask[addr[`SEE_PAGE_W-1:0]] <= 1'b1;
						addr[`SEE_PAGE_W-1:0] <=
							addr[`SEE_PAGE_W-1:0] + 5'h01;
						byte_done <= 1'b1;
					end
					S_SRD: begin
						out_sr <= stat_now; // repeated status
					end
					S_SWR: begin
						stat_new <= byte_in;
						byte_done <= 1'b1;
						state <= S_IGN;
					end
					S_IGN: begin
						state <= S_IGN;
					end
					default: state <= S_IGN;
					endcase
				end
			end
		end
	end

endmodule // see_slave
`default_nettype wire

// ===== see_defines.vh
// named constants for the serial nonvolatile byte memory slave
// assumes: included by bare name from the design file
`ifndef SEE_DEFINES_VH
`define SEE_DEFINES_VH

// instruction bytes
`define SEE_OP_READ 8'h03
`define SEE_OP_WRITE 8'h02
`define SEE_OP_LATCH_CLR 8'h04
`define SEE_OP_LATCH_SET 8'h06
`define SEE_OP_STAT_RD 8'h05
`define SEE_OP_STAT_WR 8'h01
`define SEE_OP_NONE 8'h00

// status bit positions
`define SEE_ST_BUSY 0
`define SEE_ST_LATCH 1
`define SEE_ST_GUARD0 2
`define SEE_ST_GUARD1 3
`define SEE_ST_GATE 7

// array geometry
`define SEE_ADDR_W 12
`define SEE_DEPTH 4096
`define SEE_PAGE_W 5
`define SEE_PAGE_BYTES 32
`define SEE_LAST_BIT 3'h7

// timing: internal write time and clock period in ns
`define SEE_TWC_NS 5000000
`define SEE_CLK_NS 100
`define SEE_TWC_CYCLES (`SEE_TWC_NS / `SEE_CLK_NS)

`endif

// ===== see_slave_asserts.sv
// concurrent checks on the pins and flags of the serial memory slave
// assumes: clk_en held high, sck half period at least four mclk
`timescale 1ns/1ps
`default_nettype none
module see_slave_asserts (
	// clock and reset
	input wire mclk,
	input wire rst,
	// link pins
	input wire cs_n,
	input wire sck,
	input wire hold_n,
	input wire so_out,
	input wire so_oe,
	// status flags
	input wire busy_flag,
	input wire write_latch_flag,
	input wire protect_pin_gate_bit,
	input wire block_guard_bit0,
	input wire block_guard_bit1
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// six cycles covers the pin synchroniser and the output register
	cs_hiz_a: assert property (cs_n [*6] |-> !so_oe)
		else $error("output driven while deselected");
	hold_hiz_a: assert property (!hold_n [*6] |-> !so_oe)
		else $error("output driven while paused");
	busy_len_a: assert property ($rose(busy_flag) |-> busy_flag [*8])
		else $error("write cycle cut short");
	busy_start_a: assert property ($rose(busy_flag) |->
		cs_n && write_latch_flag)
		else $error("write cycle started without latch or select rise");
	busy_end_a: assert property ($fell(busy_flag) |-> !write_latch_flag)
		else $error("latch still set after write cycle");
	latch_rise_a: assert property ($rose(write_latch_flag) |-> cs_n)
		else $error("latch set while still selected");
	// status bits move only when a programming cycle completes
	stat_move_a: assert property (!$stable({protect_pin_gate_bit,
		block_guard_bit1, block_guard_bit0}) |-> $fell(busy_flag))
		else $error("status bits changed outside a write cycle");
	// a new output bit appears only while sck has been low for a while
	so_edge_a: assert property (so_oe && $past(so_oe) &&
		$changed(so_out) |-> !$past(sck, 2))
		else $error("output bit changed away from a falling edge");
endmodule // see_slave_asserts
bind see_slave see_slave_asserts see_slave_asserts_i (.mclk(mclk), .rst(rst),
	.cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe),
	.busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
	.protect_pin_gate_bit(protect_pin_gate_bit),
	.block_guard_bit0(block_guard_bit0), .block_guard_bit1(block_guard_bit1));
`default_nettype wire

// ===== see_spi_master.sv
// behavioural link master: frames, bytes at an 800 ns sck, pauses
// assumes: mclk at 100 ns; released output line is resolved here
`timescale 1ns/1ps
`default_nettype none
module see_spi_master (
	// clock
	input wire mclk,
	// link pins driven
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic hold_n,
	// returned data
	input wire so_out,
	input wire so_oe
);
	logic last = 1'b0; // last resolved level of the data out line
	// idle link: deselected, clock parked low, no pause
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic sel();
		tick(1);
		cs_n <= 1'b0;
		tick(4);
	endtask
	// rise right after the last bit, so a whole byte commits
	task automatic desel();
		tick(4);
		cs_n <= 1'b1;
		tick(8);
	endtask
	// nb bits msb first; read back mid high phase, well clear of the fall
	task automatic xfer(input logic [7:0] tx, input int nb,
		output logic [7:0] rx);
		for (int i = 7; i > 7 - nb; i--) begin
			si <= tx[i];
			tick(4);
			sck <= 1'b1;
			tick(2);
			last = so_oe ? so_out : ~last; // released line never repeats
			rx[i] = last;
			tick(2);
			sck <= 1'b0;
		end
	endtask
	// pause with sck low, report the enable seen, resume with sck low
	task automatic pause(output logic seen_oe);
		hold_n <= 1'b0;
		tick(12);
		seen_oe = so_oe;
		hold_n <= 1'b1;
		tick(4);
	endtask
endmodule // see_spi_master
`default_nettype wire

// ===== see_slave_tb_top.sv
// self-checking bench of the serial memory slave
// assumes: the master model and checker files compile first
`timescale 1ns/1ps
`default_nettype none
module see_slave_tb_top;
	logic mclk = 1'b0; // 10 MHz system clock
	logic rst = 1'b1;
	logic wp_n = 1'b1; // write-protect pin
	wire cs_n, sck, si, hold_n, so_out, so_oe, busy_flag, write_latch_flag;
	wire protect_pin_gate_bit, block_guard_bit0, block_guard_bit1;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] rx;
	logic oe;
	always #50 mclk = ~mclk;
	// long enough for the write cycles used here
	see_slave #(.WRITE_CYCLES(600)) see_slave_i (.mclk(mclk), .rst(rst),
		.clk_en(1'b1), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
		.wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy_flag(busy_flag),
		.write_latch_flag(write_latch_flag),
		.protect_pin_gate_bit(protect_pin_gate_bit),
		.block_guard_bit0(block_guard_bit0),
		.block_guard_bit1(block_guard_bit1));
	see_spi_master m (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si),
		.hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));
	// cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic op(input logic [7:0] c);
		m.sel();
		m.xfer(c, 8, rx);
		m.desel();
	endtask
	task automatic cmd(input logic [7:0] c, input logic [15:0] a);
		m.sel();
		m.xfer(c, 8, rx);
		m.xfer(a[15:8], 8, rx);
		m.xfer(a[7:0], 8, rx);
	endtask
	task automatic idle();
		for (int k = 0; k < 1000 && busy_flag !== 1'b0; k++)
			@(posedge mclk);
	endtask
	task automatic stat();
		m.sel();
		m.xfer(8'h05, 8, rx);
		m.xfer(8'h00, 8, rx);
		m.desel();
	endtask
	// latched write of the low n bytes of d, highest byte first
	task automatic wr(input logic [15:0] a, input int n, input logic [23:0] d);
		op(8'h06);
		cmd(8'h02, a);
		for (int k = n - 1; k >= 0; k--)
			m.xfer(d[8*k +: 8], 8, rx);
		m.desel();
	endtask
	task automatic sw(input logic [7:0] d);
		op(8'h06);
		m.sel();
		m.xfer(8'h01, 8, rx);
		m.xfer(d, 8, rx);
		m.desel();
		idle();
	endtask
	task automatic t_latch();
		stat();
		check(rx, 8'h00);
		op(8'h06);
		check(8'(write_latch_flag), 8'h01);
		op(8'h04);
		check(8'(write_latch_flag), 8'h00);
		m.sel();
		m.xfer(8'h06, 8, rx);
		m.xfer(8'h02, 8, rx);
		m.desel();
		check(8'(write_latch_flag), 8'h00);
	endtask
	task automatic t_page();
		wr(16'hfffe, 3, 24'ha5_5ac3);
		check(8'(busy_flag), 8'h01);
		stat();
		check(rx, 8'h03);
		cmd(8'h03, 16'h0ffe);
		m.xfer(8'h00, 8, rx);
		check(8'(so_oe), 8'h00);
		m.desel();
		idle();
		check(8'(write_latch_flag), 8'h00);
		wr(16'h0000, 1, 24'h00_003c);
		idle();
		cmd(8'h03, 16'hfffe);
		m.xfer(8'h00, 8, rx);
		check(rx, 8'ha5);
		m.pause(oe);
		check(8'(oe), 8'h00);
		m.xfer(8'h00, 8, rx);
		check(rx, 8'h5a);
		m.xfer(8'h00, 8, rx);
		check(rx, 8'h3c);
		m.desel();
		cmd(8'h03, 16'h0fe0);
		m.xfer(8'h00, 8, rx);
		check(rx, 8'hc3);
		m.desel();
	endtask
	task automatic t_abort();
		op(8'h06);
		cmd(8'h02, 16'h0000);
		m.xfer(8'h11, 4, rx);
		m.desel();
		check(8'(busy_flag), 8'h00);
		op(8'h04);
		cmd(8'h02, 16'h0000);
		m.xfer(8'h11, 8, rx);
		m.desel();
		check(8'(busy_flag), 8'h00);
		m.sel();
		m.xfer(8'hff, 8, rx);
		m.xfer(8'h05, 8, rx);
		m.xfer(8'h00, 8, rx);
		check(8'(so_oe), 8'h00);
		m.desel();
		cmd(8'h03, 16'h0000);
		m.xfer(8'h00, 8, rx);
		check(rx, 8'h3c);
		m.desel();
	endtask
	task automatic t_protect();
		sw(8'h8c);
		check(8'({protect_pin_gate_bit, block_guard_bit1,
			block_guard_bit0}), 8'h07);
		wp_n <= 1'b0;
		sw(8'h00);
		check(8'(protect_pin_gate_bit), 8'h01);
		wp_n <= 1'b1;
		sw(8'h00);
		check(8'(protect_pin_gate_bit), 8'h00);
		wp_n <= 1'b0;
		sw(8'h0c);
		check(8'({block_guard_bit1, block_guard_bit0}), 8'h03);
		// a status write already committed ignores the pin falling later
		wp_n <= 1'b1;
		sw(8'h80);
		check(8'(protect_pin_gate_bit), 8'h01);
		op(8'h06);
		m.sel();
		m.xfer(8'h01, 8, rx);
		m.xfer(8'h8c, 8, rx);
		m.desel();
		wp_n <= 1'b0;
		idle();
		check(8'({block_guard_bit1, block_guard_bit0}), 8'h03);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		t_latch();
		t_page();
		t_abort();
		t_protect();
		finish_test();
	end
endmodule // see_slave_tb_top
`default_nettype wire
